// ===== rtl/lrs_pkg.sv
/*
  Package for the load rate selector: register offsets, field positions,
  reset values, widths and timing constants.
  Assumes a 40 MHz clock and a 16-bit register port.
*/
package lrs_pkg;

  // Register offsets (word addresses on the plain register port).
  localparam logic [3:0] LRS_REG_CONFIG       = 4'h0;
  localparam logic [3:0] LRS_REG_RATED_CHARGE = 4'h1;
  localparam logic [3:0] LRS_REG_RATED_ENERGY = 4'h2;
  localparam logic [3:0] LRS_REG_RES_CHARGE   = 4'h3;
  localparam logic [3:0] LRS_REG_RES_ENERGY   = 4'h4;
  localparam logic [3:0] LRS_REG_USER_CUR     = 4'h5;
  localparam logic [3:0] LRS_REG_USER_PWR     = 4'h6;
  localparam logic [3:0] LRS_REG_PROBE_RATE   = 4'h7;
  localparam logic [3:0] LRS_REG_DSG_THRESH   = 4'h8;
  localparam logic [3:0] LRS_REG_CHG_THRESH   = 4'h9;
  localparam logic [3:0] LRS_REG_LAST_CUR     = 4'hA;
  localparam logic [3:0] LRS_REG_LAST_PWR     = 4'hB;
  localparam logic [3:0] LRS_REG_RATE         = 4'hC;
  localparam logic [3:0] LRS_REG_STATUS       = 4'hD;

  // Configuration register fields.
  localparam int LRS_CFG_MODE_BIT  = 0;
  localparam int LRS_CFG_SEL_LSB   = 1;
  localparam int LRS_CFG_SEL_MSB   = 3;
  localparam int LRS_CFG_SCALE_BIT = 4;
  localparam int LRS_CFG_RESC_BIT  = 5;

  // Status register fields.
  localparam int LRS_ST_DSG_BIT = 0;
  localparam int LRS_ST_CHG_BIT = 1;

  // Reset values, mode codes and the selector limit.
  localparam logic       LRS_MODE_CURRENT = 1'b0;
  localparam logic       LRS_MODE_POWER   = 1'b1;
  localparam logic [2:0] LRS_SEL_DEFAULT  = 3'h1;
  localparam logic [2:0] LRS_SEL_MAX      = 3'h6;
  localparam logic [15:0] LRS_THRESH_RST  = 16'h0064;

  // Selector codes.
  localparam logic [2:0] LRS_SEL_LAST   = 3'h0;
  localparam logic [2:0] LRS_SEL_PRES   = 3'h1;
  localparam logic [2:0] LRS_SEL_AVG    = 3'h2;
  localparam logic [2:0] LRS_SEL_FILT   = 3'h3;
  localparam logic [2:0] LRS_SEL_RATED  = 3'h4;
  localparam logic [2:0] LRS_SEL_PROBE  = 3'h5;
  localparam logic [2:0] LRS_SEL_USER   = 3'h6;

  // Fixed factors.
  localparam int LRS_RATED_DIV  = 5;
  localparam int LRS_SCALE_TEN  = 10;

  // Filter timing: one update per tick, time constant in seconds.
  localparam int LRS_CLK_HZ      = 40_000_000;
  localparam int LRS_TICK_MS     = 1;
  localparam int LRS_TICK_CYCLES = LRS_CLK_HZ / 1000 * LRS_TICK_MS;
  localparam int LRS_FILT_TAU_S  = 14;
  // Shift that makes 2^k ticks closest to the time constant (14000 ms).
  localparam int LRS_FILT_SHIFT  = 14;

endpackage

// ===== rtl/lrs_filter.sv
/*
  First-order low-pass filter on the averaged current reading.
  Assumes a one-cycle update enable from the parent's tick divider.
*/
`timescale 1ns/1ps
module lrs_filter
  import lrs_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int SHIFT = LRS_FILT_SHIFT
) (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // Sample stream.
  input  wire logic                    tick_i,
  input  wire logic signed [WIDTH-1:0] sample_i,
  output logic signed [WIDTH-1:0]      filt_o
);

  initial begin
    if (SHIFT < 1 || SHIFT > 20) $error("lrs_filter: bad SHIFT");
  end

  logic signed [WIDTH+SHIFT-1:0] acc;
  logic signed [WIDTH+SHIFT-1:0] next_acc;
  wire  signed [WIDTH+SHIFT-1:0] sample_ext = (WIDTH+SHIFT)'(sample_i);
  wire  signed [WIDTH+SHIFT-1:0] acc_out = acc >>> SHIFT;

  // Accumulator tracks sample at rate 2^-SHIFT per tick.
  assign next_acc = acc + sample_ext - acc_out;

  // The accumulator holds extra fraction bits so small steps are not lost.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= '0;
    end else if (tick_i) begin
      acc <= next_acc;
    end
  end

  assign filt_o = acc_out[WIDTH-1:0];

endmodule // lrs_filter

// ===== rtl/lrs_selector.sv
/*
  Load rate selector: picks the rate that feeds load-compensated capacity,
  holds reserve and scale settings and flags significant current.
  Assumes synchronous measurement inputs and a plain register port.
*/
`timescale 1ns/1ps

module lrs_selector
  import lrs_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // Register port.
  input  wire logic [3:0]           addr_i,
  input  wire logic [DW-1:0]        wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic [DW-1:0]             rdata_o,
  // Measurements; current is signed, positive means charge.
  input  wire logic signed [DW-1:0] avg_current_reading_i,
  input  wire logic [DW-1:0]        cell_voltage_i,
  input  wire logic [DW-1:0]        present_avg_current_i,
  input  wire logic [DW-1:0]        present_avg_power_i,
  input  wire logic                 dsg_cycle_end_i,
  // Selected rate and derived settings.
  output logic [2*DW-1:0]           load_rate_o,
  output logic                      power_mode_o,
  output logic [DW+3:0]             reserve_charge_o,
  output logic [DW+3:0]             reserve_energy_o,
  output logic                      reserve_comp_o,
  output logic [3:0]                trise_mult_o,
  output logic                      dsg_sig_o,
  output logic                      chg_sig_o
);

  initial begin
    if (DW < 8 || DW > 16) $error("lrs_selector: DW must be 8..16");
  end

  // Reset release through two flip-flops.
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Settings written by software.
  logic          mode;
  logic [2:0]    sel;
  logic          scale_ten;
  logic          res_comp;
  logic [DW-1:0] rated_charge;
  logic [DW-1:0] rated_energy;
  logic [DW-1:0] res_charge;
  logic [DW-1:0] res_energy;
  logic [DW-1:0] user_current_rate;
  logic [DW-1:0] user_power_rate;
  logic [DW-1:0] probe_rate_value;
  logic [DW-1:0] dsg_thresh;
  logic [DW-1:0] chg_thresh;
  logic [DW-1:0] last_current;
  logic [DW-1:0] last_power;

  // Write decode.
  wire wr_cfg = wr_i && addr_i == LRS_REG_CONFIG;
  wire [2:0] wr_sel = wdata_i[LRS_CFG_SEL_MSB:LRS_CFG_SEL_LSB];

  // Configuration register; out-of-range selectors are stored as written
  // and mapped at use, so software reads back what it wrote.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= LRS_MODE_CURRENT;
      sel       <= LRS_SEL_DEFAULT;
      scale_ten <= 1'b0;
      res_comp  <= 1'b0;
    end else if (wr_cfg) begin
      mode      <= wdata_i[LRS_CFG_MODE_BIT];
      sel       <= wr_sel;
      scale_ten <= wdata_i[LRS_CFG_SCALE_BIT];
      res_comp  <= wdata_i[LRS_CFG_RESC_BIT];
    end
  end

  // Data registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rated_charge      <= '0;
      rated_energy      <= '0;
      res_charge        <= '0;
      res_energy        <= '0;
      user_current_rate <= '0;
      user_power_rate   <= '0;
      probe_rate_value  <= '0;
      dsg_thresh        <= DW'(LRS_THRESH_RST);
      chg_thresh        <= DW'(LRS_THRESH_RST);
    end else if (wr_i) begin
      case (addr_i)
        LRS_REG_RATED_CHARGE: rated_charge      <= wdata_i;
        LRS_REG_RATED_ENERGY: rated_energy      <= wdata_i;
        LRS_REG_RES_CHARGE:   res_charge        <= wdata_i;
        LRS_REG_RES_ENERGY:   res_energy        <= wdata_i;
        LRS_REG_USER_CUR:     user_current_rate <= wdata_i;
        LRS_REG_USER_PWR:     user_power_rate   <= wdata_i;
        LRS_REG_PROBE_RATE:   probe_rate_value  <= wdata_i;
        LRS_REG_DSG_THRESH:   dsg_thresh        <= wdata_i;
        LRS_REG_CHG_THRESH:   chg_thresh        <= wdata_i;
        default: ;
      endcase
    end
  end

  // Last-run averages are captured at the end of each discharge cycle;
  // software may preload them, but a cycle end in the same cycle wins.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_current <= '0;
      last_power   <= '0;
    end else if (dsg_cycle_end_i) begin
      last_current <= present_avg_current_i;
      last_power   <= present_avg_power_i;
    end else if (wr_i && addr_i == LRS_REG_LAST_CUR) begin
      last_current <= wdata_i;
    end else if (wr_i && addr_i == LRS_REG_LAST_PWR) begin
      last_power <= wdata_i;
    end
  end

  // Millisecond tick for the current filter.
  localparam int TCW = $clog2(LRS_TICK_CYCLES);
  logic [TCW-1:0] tick_cnt;
  wire            tick = tick_cnt == TCW'(LRS_TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // Filtered current, time constant about 16.4 s (2^14 ticks) at a 1 ms tick.
  logic signed [DW-1:0] filt_current;
  lrs_filter #(
    .WIDTH (DW),
    .SHIFT (LRS_FILT_SHIFT)
  ) u_filter (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .tick_i   (tick),
    .sample_i (avg_current_reading_i),
    .filt_o   (filt_current)
  );

  // Discharge magnitudes; a charging current gives zero load.
  wire [DW-1:0] avg_mag = avg_current_reading_i[DW-1] ?
                          DW'(-avg_current_reading_i) : '0;
  wire [DW-1:0] filt_mag = filt_current[DW-1] ? DW'(-filt_current) : '0;

  // Effective selector; out of range falls back to the default.
  wire [2:0] eff_sel = (sel > LRS_SEL_MAX) ? LRS_SEL_DEFAULT : sel;

  // Energy terms scaled by ten in centi-unit mode.
  wire [3:0] scale = scale_ten ? 4'(LRS_SCALE_TEN) : 4'h1;
  // Both factors are widened first so the product keeps its carry bits.
  wire [DW+3:0] scale_w        = (DW+4)'(scale);
  wire [DW+3:0] rated_energy_s = (DW+4)'(rated_energy) * scale_w;
  wire [DW+3:0] user_power_s   = (DW+4)'(user_power_rate) * scale_w;
  wire [DW+3:0] last_power_s   = (DW+4)'(last_power) * scale_w;

  // Current-mode candidates.
  logic [2*DW-1:0] cur_rate;
  always_comb begin
    case (eff_sel)
      LRS_SEL_LAST:  cur_rate = (2*DW)'(last_current);
      LRS_SEL_PRES:  cur_rate = (2*DW)'(present_avg_current_i);
      LRS_SEL_AVG:   cur_rate = (2*DW)'(avg_mag);
      LRS_SEL_FILT:  cur_rate = (2*DW)'(filt_mag);
      LRS_SEL_RATED: cur_rate = (2*DW)'(rated_charge / LRS_RATED_DIV);
      LRS_SEL_PROBE: cur_rate = (2*DW)'(probe_rate_value);
      LRS_SEL_USER:  cur_rate = (2*DW)'(user_current_rate);
      default:       cur_rate = (2*DW)'(present_avg_current_i);
    endcase
  end

  // Power-mode candidates.
  logic [2*DW-1:0] pwr_rate;
  always_comb begin
    case (eff_sel)
      LRS_SEL_LAST:  pwr_rate = (2*DW)'(last_power_s);
      LRS_SEL_PRES:  pwr_rate = (2*DW)'(present_avg_power_i);
      LRS_SEL_AVG:   pwr_rate = avg_mag * cell_voltage_i;
      LRS_SEL_FILT:  pwr_rate = filt_mag * cell_voltage_i;
      LRS_SEL_RATED: pwr_rate = (2*DW)'(rated_energy_s / LRS_RATED_DIV);
      LRS_SEL_PROBE: pwr_rate = (2*DW)'(probe_rate_value);
      LRS_SEL_USER:  pwr_rate = (2*DW)'(user_power_s);
      default:       pwr_rate = (2*DW)'(present_avg_power_i);
    endcase
  end

  // Registered outputs; the rate lags its inputs by one cycle.
  wire [2*DW-1:0] next_rate = mode ? pwr_rate : cur_rate;
  wire next_dsg = avg_current_reading_i[DW-1] && avg_mag > dsg_thresh;
  wire signed [DW:0] chg_ext = (DW+1)'(avg_current_reading_i);
  wire next_chg = !avg_current_reading_i[DW-1] &&
                  DW'(chg_ext) > chg_thresh;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      load_rate_o <= '0;
      dsg_sig_o   <= 1'b0;
      chg_sig_o   <= 1'b0;
    end else begin
      load_rate_o <= next_rate;
      dsg_sig_o   <= next_dsg;
      chg_sig_o   <= next_chg;
    end
  end

  // Reserve settings pass to the capacity engine with the no-load flag.
  assign power_mode_o     = mode;
  assign reserve_charge_o = (DW+4)'(res_charge);
  assign reserve_energy_o = (DW+4)'(res_energy) * scale_w;
  assign reserve_comp_o   = res_comp;
  assign trise_mult_o     = scale;

  // Read multiplexer; unmapped addresses read as zero.
  logic [DW-1:0] rd_mux;
  always_comb begin
    case (addr_i)
      LRS_REG_CONFIG: begin
        rd_mux = '0;
        rd_mux[LRS_CFG_MODE_BIT] = mode;
        rd_mux[LRS_CFG_SEL_MSB:LRS_CFG_SEL_LSB] = sel;
        rd_mux[LRS_CFG_SCALE_BIT] = scale_ten;
        rd_mux[LRS_CFG_RESC_BIT] = res_comp;
      end
      LRS_REG_RATED_CHARGE: rd_mux = rated_charge;
      LRS_REG_RATED_ENERGY: rd_mux = rated_energy;
      LRS_REG_RES_CHARGE:   rd_mux = res_charge;
      LRS_REG_RES_ENERGY:   rd_mux = res_energy;
      LRS_REG_USER_CUR:     rd_mux = user_current_rate;
      LRS_REG_USER_PWR:     rd_mux = user_power_rate;
      LRS_REG_PROBE_RATE:   rd_mux = probe_rate_value;
      LRS_REG_DSG_THRESH:   rd_mux = dsg_thresh;
      LRS_REG_CHG_THRESH:   rd_mux = chg_thresh;
      LRS_REG_LAST_CUR:     rd_mux = last_current;
      LRS_REG_LAST_PWR:     rd_mux = last_power;
      LRS_REG_RATE:         rd_mux = load_rate_o[DW-1:0];
      LRS_REG_STATUS: begin
        rd_mux = '0;
        rd_mux[LRS_ST_DSG_BIT] = dsg_sig_o;
        rd_mux[LRS_ST_CHG_BIT] = chg_sig_o;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  // Assertions.
  a_mode_current: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode && eff_sel == LRS_SEL_USER |=> load_rate_o == (2*DW)'($past(user_current_rate)))
    else $error("current user rate not selected");
  a_sel_default: assert property (@(posedge clk_i) disable iff (!rst_n)
    sel == 3'h7 |-> eff_sel == LRS_SEL_PRES)
    else $error("out of range selector not mapped");
  a_pres_cur: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode && eff_sel == LRS_SEL_PRES |=> load_rate_o == (2*DW)'($past(present_avg_current_i)))
    else $error("present current not selected");
  a_probe_rate: assert property (@(posedge clk_i) disable iff (!rst_n)
    eff_sel == LRS_SEL_PROBE |=> load_rate_o == (2*DW)'($past(probe_rate_value)))
    else $error("probe rate not selected");
  a_power_avg: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode && eff_sel == LRS_SEL_AVG |=> load_rate_o == $past(avg_mag) * $past(cell_voltage_i))
    else $error("power product wrong");
  a_last_capture: assert property (@(posedge clk_i) disable iff (!rst_n)
    dsg_cycle_end_i |=> last_current == $past(present_avg_current_i))
    else $error("last run current not captured");
  a_dsg_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    dsg_sig_o |-> $past(avg_current_reading_i[DW-1]) && $past(avg_mag) > $past(dsg_thresh))
    else $error("discharge flag without cause");
  a_chg_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    chg_sig_o |-> !$past(avg_current_reading_i[DW-1]))
    else $error("charge flag during discharge");
  a_scale_ten: assert property (@(posedge clk_i) disable iff (!rst_n)
    scale_ten |-> trise_mult_o == 4'hA)
    else $error("scale ten not applied");

  // More sources, one assertion each, then unscaled reserve energy; current LAST, power PRES and power FILT have none.
  a_cur_avg: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode && eff_sel == LRS_SEL_AVG |=>
    load_rate_o == (2*DW)'($past(avg_mag)))
    else $error("averaged current not selected");
  a_cur_filt: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode && eff_sel == LRS_SEL_FILT |=>
    load_rate_o == (2*DW)'($past(filt_mag)))
    else $error("filtered current not selected");
  a_cur_rated: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode && eff_sel == LRS_SEL_RATED |=>
    load_rate_o == (2*DW)'($past(rated_charge) / LRS_RATED_DIV))
    else $error("rated charge rate wrong");
  a_pwr_last: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode && eff_sel == LRS_SEL_LAST |=>
    load_rate_o == (2*DW)'($past(last_power_s)))
    else $error("last run power not selected");
  a_pwr_rated: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode && eff_sel == LRS_SEL_RATED |=>
    load_rate_o == (2*DW)'($past(rated_energy_s) / LRS_RATED_DIV))
    else $error("rated energy rate wrong");
  a_pwr_user: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode && eff_sel == LRS_SEL_USER |=>
    load_rate_o == (2*DW)'($past(user_power_s)))
    else $error("user power rate not selected");
  a_res_plain: assert property (@(posedge clk_i) disable iff (!rst_n)
    !scale_ten |->
    reserve_energy_o == (DW+4)'(res_energy))
    else $error("reserve energy scaled at unit scale");

endmodule // lrs_selector

// ===== test/tb_top.sv
/*
  Self-checking bench for the load rate selector: walks every mode,
  selector and scale setting, the reserve outputs and the current flags.
  Assumes the selector alone, driven straight from this module.
*/
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  end \
end

module tb_top;
  import lrs_pkg::*;

  logic                clk_i = 1'b0;
  logic                reset_n_i;
  logic [3:0]          addr_i;
  logic [15:0]         wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [15:0]         rdata_o;
  logic signed [15:0]  avg_current_reading_i;
  logic [15:0]         cell_voltage_i;
  logic [15:0]         present_avg_current_i;
  logic [15:0]         present_avg_power_i;
  logic                dsg_cycle_end_i;
  logic [31:0]         load_rate_o;
  logic                power_mode_o;
  logic [19:0]         reserve_charge_o;
  logic [19:0]         reserve_energy_o;
  logic                reserve_comp_o;
  logic [3:0]          trise_mult_o;
  logic                dsg_sig_o;
  logic                chg_sig_o;
  int                  err_total;
  int                  checks_done;
  logic [31:0]         seed = 32'h0000D981;
  logic [15:0]         rc, re, rq, rn, uc, up, pr, lc, lp, rdv, cfg, t, tc;
  logic [31:0]         m;

  // Free-running 40 MHz clock.
  always #12.5 clk_i = ~clk_i;

  lrs_selector #(.DW(16)) lrs_selector_inst (
    .clk_i                 (clk_i),
    .reset_n_i             (reset_n_i),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .rdata_o               (rdata_o),
    .avg_current_reading_i (avg_current_reading_i),
    .cell_voltage_i        (cell_voltage_i),
    .present_avg_current_i (present_avg_current_i),
    .present_avg_power_i   (present_avg_power_i),
    .dsg_cycle_end_i       (dsg_cycle_end_i),
    .load_rate_o           (load_rate_o),
    .power_mode_o          (power_mode_o),
    .reserve_charge_o      (reserve_charge_o),
    .reserve_energy_o      (reserve_energy_o),
    .reserve_comp_o        (reserve_comp_o),
    .trise_mult_o          (trise_mult_o),
    .dsg_sig_o             (dsg_sig_o),
    .chg_sig_o             (chg_sig_o)
  );

  // Xorshift generator; a fixed start keeps every run identical.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected rate from the mirrored settings and the live inputs.
  function automatic logic [31:0] exp_rate(logic md, logic [2:0] sel,
                                           logic sc);
    logic [31:0] k;
    logic [15:0] am;
    k = sc ? 32'h0000000A : 32'h00000001;
    // Discharge magnitude; a charging current gives no load.
    am = avg_current_reading_i[15] ?
         16'h0000 - avg_current_reading_i : 16'h0000;
    if (!md) begin
      case (sel)
        3'h0: return {16'h0000, lc};
        3'h2: return {16'h0000, am};
        3'h4: return {16'h0000, rc} / LRS_RATED_DIV;
        3'h5: return {16'h0000, pr};
        3'h6: return {16'h0000, uc};
        default: return {16'h0000, present_avg_current_i};
      endcase
    end
    case (sel)
      3'h0: return {16'h0000, lp} * k;
      3'h2: return {16'h0000, am} * {16'h0000, cell_voltage_i};
      3'h4: return {16'h0000, re} * k / LRS_RATED_DIV;
      3'h5: return {16'h0000, pr};
      3'h6: return {16'h0000, up} * k;
      default: return {16'h0000, present_avg_power_i};
    endcase
  endfunction

  // Single-cycle write; the leading edge keeps strobes from colliding.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Single-cycle read; data stands only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Drives the averaged current and lets the registered flags follow.
  task automatic cur(input logic [15:0] v);
    @(posedge clk_i);
    avg_current_reading_i <= v;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs about 41000 cycles, most of them
  // spent waiting for one filter tick.
  initial begin
    #2000000;
    err_total++;
    conclude();
  end

  initial begin
    reset_n_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    avg_current_reading_i = 16'sh0000;
    cell_voltage_i = 16'h0000;
    present_avg_current_i = 16'h0000;
    present_avg_power_i = 16'h0000;
    dsg_cycle_end_i = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    // Reset state; the filter has seen only zero input so far.
    `CHK("trise", 4'h1, trise_mult_o)
    `CHK("mode", 1'b0, power_mode_o)
    rd(LRS_REG_CONFIG, rdv);
    `CHK("config", 16'h0002, rdv)
    rd(LRS_REG_DSG_THRESH, rdv);
    `CHK("dsg_thr", 16'h0064, rdv)
    rd(LRS_REG_CHG_THRESH, rdv);
    `CHK("chg_thr", 16'h0064, rdv)
    wr(4'hE, 16'hFFFF);
    rd(4'hE, rdv);
    `CHK("unmapped", 16'h0000, rdv)
    wr(LRS_REG_CONFIG, 16'h0006);
    rd(LRS_REG_CONFIG, rdv);
    `CHK("filt_c", 32'h0, load_rate_o)
    wr(LRS_REG_CONFIG, 16'h0007);
    rd(LRS_REG_CONFIG, rdv);
    `CHK("filt_p", 32'h0, load_rate_o)
    $display("test reset done");
    // Random settings, then every mode, scale and selector code except the filter (3).
    for (int i = 0; i < 8; i++) begin
      rc = 16'(rnd());
      re = 16'(rnd());
      rq = 16'(rnd());
      rn = 16'(rnd());
      uc = 16'(rnd());
      up = 16'(rnd());
      pr = 16'(rnd()) & 16'h7FFF;
      wr(LRS_REG_RATED_CHARGE, rc);
      wr(LRS_REG_RATED_ENERGY, re);
      wr(LRS_REG_RES_CHARGE, rq);
      wr(LRS_REG_RES_ENERGY, rn);
      wr(LRS_REG_USER_CUR, uc);
      wr(LRS_REG_USER_PWR, up);
      wr(LRS_REG_PROBE_RATE, pr);
      @(posedge clk_i);
      present_avg_current_i <= 16'(rnd());
      present_avg_power_i <= 16'(rnd());
      dsg_cycle_end_i <= 1'b1;
      @(posedge clk_i);
      dsg_cycle_end_i <= 1'b0;
      lc = present_avg_current_i;
      lp = present_avg_power_i;
      // Move the present averages so last-run and present differ.
      present_avg_current_i <= 16'(rnd());
      present_avg_power_i <= 16'(rnd());
      // Odd passes force a discharge so the magnitude paths see both signs.
      avg_current_reading_i <= 16'(rnd()) | (i[0] ? 16'h8000 : 16'h0000);
      cell_voltage_i <= 16'(rnd());
      rd(LRS_REG_LAST_CUR, rdv);
      `CHK("last_cur", lc, rdv)
      for (int k = 0; k < 32; k++) begin
        if (k[4:2] != 3'h3) begin
          cfg = {10'h000, 1'(rnd()), k[1], k[4:2], k[0]};
          m = k[1] ? 32'h0000000A : 32'h00000001;
          wr(LRS_REG_CONFIG, cfg);
          rd(LRS_REG_CONFIG, rdv);
          `CHK("config", cfg, rdv)
          if (!k[0]) `CHK("crate", exp_rate(1'b0, k[4:2], k[1]), load_rate_o)
          else `CHK("prate", exp_rate(1'b1, k[4:2], k[1]), load_rate_o)
          `CHK("mode", k[0], power_mode_o)
          `CHK("trise", k[1] ? 4'hA : 4'h1, trise_mult_o)
          `CHK("res_c", {4'h0, rq}, reserve_charge_o)
          `CHK("res_e", 20'({4'h0, rn} * m), reserve_energy_o)
          `CHK("res_cmp", cfg[5], reserve_comp_o)
        end
      end
      wr(LRS_REG_RATE, 16'hFFFF);
      rd(LRS_REG_RATE, rdv);
      `CHK("rate_rd", 16'(exp_rate(cfg[0], cfg[3:1], cfg[4])), rdv)
    end
    $display("test selection done");
    // Flags at and one step past each threshold.
    t = (16'(rnd()) & 16'h3FFF) | 16'h0001;
    tc = (16'(rnd()) & 16'h3FFF) | 16'h0001;
    wr(LRS_REG_DSG_THRESH, t);
    wr(LRS_REG_CHG_THRESH, tc);
    cur(16'h0000 - t);
    `CHK("dsg_eq", 1'b0, dsg_sig_o)
    cur(16'h0000 - t - 16'h0001);
    `CHK("dsg_abv", 1'b1, dsg_sig_o)
    `CHK("chg_off", 1'b0, chg_sig_o)
    wr(LRS_REG_STATUS, 16'h0000);
    rd(LRS_REG_STATUS, rdv);
    `CHK("status", 16'h0001, rdv)
    cur(tc);
    `CHK("chg_eq", 1'b0, chg_sig_o)
    cur(tc + 16'h0001);
    `CHK("chg_abv", 1'b1, chg_sig_o)
    `CHK("dsg_off", 1'b0, dsg_sig_o)
    rd(LRS_REG_STATUS, rdv);
    `CHK("status", 16'h0002, rdv)
    $display("test thresholds done");
    // One filter step from rest: no tick has passed yet, so exactly one
    // tick falls in the wait and moves the output by 2^-shift of the step.
    wr(LRS_REG_CONFIG, 16'h0006);
    @(posedge clk_i);
    avg_current_reading_i <= 16'h8000;
    repeat (LRS_TICK_CYCLES + 2) @(posedge clk_i);
    #1;
    `CHK("filt_c1", 32'(16'h8000 >> LRS_FILT_SHIFT), load_rate_o)
    wr(LRS_REG_CONFIG, 16'h0007);
    rd(LRS_REG_CONFIG, rdv);
    `CHK("config", 16'h0007, rdv)
    m = 32'(16'h8000 >> LRS_FILT_SHIFT) * {16'h0000, cell_voltage_i};
    `CHK("filt_p1", m, load_rate_o)
    $display("test filter done");
    conclude();
  end
endmodule // tb_top
